// ===== inc/isrs_pkg.sv
/*
 * Package of the readout sequencer: array geometry, timing figures,
 * state and stream word layouts.
 * Assumes one 10 MHz clock and strobes synchronous to it.
 */
package isrs_pkg;
	// ------------------------------------------------------------
	// array geometry
	// ------------------------------------------------------------
	localparam int unsigned LINES     = 1024;
	localparam int unsigned PIXELS    = 1024;
	localparam int unsigned ROW_W     = 10;
	localparam int unsigned COL_W     = 10;
	localparam int unsigned SAMPLE_W  = 12;
	localparam logic [COL_W-1:0] LAST_COL = 10'h3FF;
	localparam logic [ROW_W-1:0] ROW_RST  = 10'h000;
	localparam logic [COL_W-1:0] COL_RST  = 10'h000;
	localparam logic [SAMPLE_W-1:0] BLACK_LEVEL = 12'h000;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS     = 100;
	localparam int unsigned LINE_CLK_PER_NS   = 200;
	localparam int unsigned LINE_CLK_HIGH_NS  = 100;
	localparam int unsigned LINE_CLK_PER_CYC  =
		(LINE_CLK_PER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned LINE_CLK_HIGH_CYC =
		(LINE_CLK_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned PIX_CLK_PER_PIXEL = 2;
	localparam int unsigned FIFO_DEPTH_DEF    = 8;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [COL_W-1:0]    column;
		logic                black;
		logic [SAMPLE_W-1:0] sample;
	} isrs_pix_t;

	localparam int unsigned PIX_W = $bits(isrs_pix_t);

	typedef struct packed {
		logic [LINES-1:0] read_ptr;
		logic [LINES-1:0] shut_ptr;
		logic [LINES-1:0] line_reset;
		logic             rd_clk_q;
		logic             sh_clk_q;
		logic             px_clk_q;
		logic [COL_W-1:0] px_col;
		logic             px_on;
		logic             px_phase;
		logic             col_sample;
		logic             col_bypass;
		logic             gain_black;
	} isrs_state_t;
endpackage

// ===== core/isrs_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/100ps
module isrs_fifo #(
	parameter int unsigned WIDTH = 23,
	parameter int unsigned DEPTH = 8
) (
	input  wire logic             i_clk,     // clock
	input  wire logic             i_resetn,  // async reset, low
	input  wire logic             i_valid,   // write request
	output logic                  o_ready,   // room for a word
	input  wire logic [WIDTH-1:0] i_data,    // write word
	output logic                  o_valid,   // word available
	input  wire logic             i_ready,   // reader takes word
	output logic [WIDTH-1:0]      o_data     // head word
);
	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction

	assign o_ready = (count != (AW+1)'(DEPTH));
	assign o_valid = (count != '0);
	assign push    = i_valid & o_ready;
	assign pop     = o_valid & i_ready;
	assign o_data  = mem[rd_ptr];

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= bump(wr_ptr);
			end
			if (pop) begin
				rd_ptr <= bump(rd_ptr);
			end
			if (push && !pop) begin
				count <= (AW+1)'(count + 1'b1);
			end else if (pop && !push) begin
				count <= (AW+1)'(count - 1'b1);
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wr_ptr] <= i_data;
		end
	end
endmodule

// ===== core/isrs_top.sv
/*
 * Line-wise readout sequencer of a 1024x1024 pixel array: two one-hot
 * line pointers, line reset routing, column sampling, pixel pointer,
 * gain black forcing and a buffered converted-sample stream.
 * Assumes an external controller drives all strobes synchronously to
 * I_CLK and keeps the readout ordering and timing itself.
 */
// Function
// R1 - controller first resets every line top to bottom, leaving array dark.
// R2 - in correlated mode either line pointer may run any phase.
// R3 - controller reads window black levels and stores them off chip.
// R4 - after exposure controller rereads window, subtracting stored black.
// R5 - 1024 lines of 1024 pixels, origin top-left, top-down, left-right.
// R6 - only window start is loaded; window end is the controller's count.
// R7 - controller reads end minus start plus one lines and pixels.
// R8 - each line is select, then blanking, then pixel readout.
// R9 - read and reset pointers may select different lines at once.
// R10 - blanking copies read line to columns; either line may be reset.
// R11 - pixel readout starts by loading pixel pointer with start column.
// R12 - line pointer clock period at least 200 ns, high 100 ns.
// R13 - destructive mode loads start registers then both pointers.
// R14 - destructive exposure: reset pointer resets and advances per line.
// R15 - destructive read: read line sampled, reset pointer also steps.
// R16 - second reset within destructive blanking is optional.
// R17 - without second reset, blanking held 100 ns more.
// R18 - calibration follows blanking by 25 ns, per frame or per line.
// R19 - calibration forces gain stage black; do it each frame.
// R20 - line pointers are one-hot, preloadable, advance one per clock.
// R21 - pixel clock runs at twice pixel rate, two cycles per pixel.
// R22 - blanking clears pixel pointer; it must be reloaded afterwards.
// R23 - pixel readout waits until the line blanking has completed.
`timescale 1ns/100ps
module isrs_top
	import isrs_pkg::*;
#(
	parameter int unsigned FIFO_DEPTH = isrs_pkg::FIFO_DEPTH_DEF
) (
	input  wire logic                         I_CLK,          // 10 MHz
	input  wire logic                         I_RESETN,       // async, low
	input  wire logic                         I_CORR_MODE,    // 1 corr ndr
	input  wire logic [isrs_pkg::ROW_W-1:0]   I_START_ROW,    // window row
	input  wire logic [isrs_pkg::COL_W-1:0]   I_START_COL,    // window col
	input  wire logic                         I_READ_PTR_CLK, // advance
	input  wire logic                         I_READ_PTR_LOAD,// preload
	input  wire logic                         I_SHUT_PTR_CLK, // advance
	input  wire logic                         I_SHUT_PTR_LOAD,// preload
	input  wire logic                         I_BLANK,        // blanking
	input  wire logic                         I_COL_PRELOAD,  // col pulse
	input  wire logic                         I_LINE_RESET,   // reset pulse
	input  wire logic                         I_PTR_CHOICE,   // 1 shutter
	input  wire logic                         I_CAL,          // gain cal
	input  wire logic                         I_PIX_CLK,      // 2x rate
	input  wire logic                         I_PIX_LOAD,     // col preload
	input  wire logic                         I_ADC_VALID,    // sample in
	input  wire logic [isrs_pkg::SAMPLE_W-1:0] I_ADC_DATA,    // sample
	input  wire logic                         I_PIX_READY,    // sink ready
	output logic [isrs_pkg::LINES-1:0]        O_READ_LINE,    // read select
	output logic [isrs_pkg::LINES-1:0]        O_SHUT_LINE,    // shut select
	output logic [isrs_pkg::LINES-1:0]        O_LINE_RESET,   // line resets
	output logic                              O_COL_SAMPLE,   // copy strobe
	output logic                              O_COL_BYPASS,   // corr bypass
	output logic                              O_GAIN_BLACK,   // cal active
	output logic [isrs_pkg::COL_W-1:0]        O_PIX_COL,      // pixel index
	output logic                              O_PIX_ACTIVE,   // ptr loaded
	output logic                              O_ADC_READY,    // room in buf
	output logic                              O_PIX_VALID,    // word out
	output isrs_pkg::isrs_pix_t               O_PIX_DATA      // stream word
);
	import isrs_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	isrs_state_t st;
	isrs_state_t next_st;
	isrs_pix_t   push_word;
	logic        rd_rise;
	logic        sh_rise;
	logic        px_rise;

	function automatic logic [LINES-1:0] one_hot(
		input logic [ROW_W-1:0] idx
	);
		logic [LINES-1:0] v;
		v = '0;
		v[idx] = 1'b1;
		one_hot = v;
	endfunction

	function automatic logic [LINES-1:0] line_step(
		input logic [LINES-1:0] p,
		input logic             load,
		input logic [ROW_W-1:0] row
	);
		// shifting past the bottom line leaves the pointer empty
		line_step = load ? one_hot(row) : {p[LINES-2:0], 1'b0};
	endfunction

	assign rd_rise = I_READ_PTR_CLK & ~st.rd_clk_q;
	assign sh_rise = I_SHUT_PTR_CLK & ~st.sh_clk_q;
	assign px_rise = I_PIX_CLK & ~st.px_clk_q;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.rd_clk_q = I_READ_PTR_CLK;
		next_st.sh_clk_q = I_SHUT_PTR_CLK;
		next_st.px_clk_q = I_PIX_CLK;
		// pointers are independent of each other [R9]
		if (rd_rise) begin
			next_st.read_ptr = line_step(st.read_ptr, I_READ_PTR_LOAD,
				I_START_ROW); // [R20] [R5]
		end
		if (sh_rise) begin
			next_st.shut_ptr = line_step(st.shut_ptr, I_SHUT_PTR_LOAD,
				I_START_ROW); // [R20] [R5]
		end
		// column copy and optional resets only during blanking
		next_st.col_sample = I_BLANK & I_COL_PRELOAD; // [R10]
		if (I_BLANK && I_LINE_RESET) begin
			next_st.line_reset = I_PTR_CHOICE ? st.shut_ptr
				: st.read_ptr; // [R10]
		end else begin
			next_st.line_reset = '0;
		end
		next_st.col_bypass = I_CORR_MODE;
		next_st.gain_black = I_CAL; // [R19]
		// pixel pointer: two pixel clock edges per pixel
		if (I_BLANK) begin
			next_st.px_on    = 1'b0; // [R22]
			next_st.px_phase = 1'b0;
		end else if (px_rise && I_PIX_LOAD) begin
			next_st.px_col   = I_START_COL;
			next_st.px_on    = 1'b1;
			next_st.px_phase = 1'b0;
		end else if (px_rise && st.px_on) begin
			next_st.px_phase = ~st.px_phase; // [R21]
			if (st.px_phase) begin
				if (st.px_col == LAST_COL) begin
					next_st.px_on = 1'b0;
				end else begin
					next_st.px_col = COL_W'(st.px_col + 1'b1); // [R5]
				end
			end
		end
	end

	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			st <= '{read_ptr: '0, shut_ptr: '0, line_reset: '0,
				rd_clk_q: 1'b0, sh_clk_q: 1'b0, px_clk_q: 1'b0,
				px_col: COL_RST, px_on: 1'b0, px_phase: 1'b0,
				col_sample: 1'b0, col_bypass: 1'b0,
				gain_black: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------
	// outputs and sample buffer
	// ------------------------------------------------------------
	assign O_READ_LINE  = st.read_ptr;
	assign O_SHUT_LINE  = st.shut_ptr;
	assign O_LINE_RESET = st.line_reset;
	assign O_COL_SAMPLE = st.col_sample;
	assign O_COL_BYPASS = st.col_bypass;
	assign O_GAIN_BLACK = st.gain_black;
	assign O_PIX_COL    = st.px_col;
	assign O_PIX_ACTIVE = st.px_on;

	// while calibrating the gain stage the stream carries black
	always_comb begin
		push_word.column = st.px_col;
		push_word.black  = st.gain_black;
		push_word.sample = st.gain_black ? BLACK_LEVEL
			: I_ADC_DATA; // [R19]
	end

	isrs_fifo #(
		.WIDTH (PIX_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_clk    (I_CLK),
		.i_resetn (I_RESETN),
		.i_valid  (I_ADC_VALID),
		.o_ready  (O_ADC_READY),
		.i_data   (push_word),
		.o_valid  (O_PIX_VALID),
		.i_ready  (I_PIX_READY),
		.o_data   (O_PIX_DATA)
	);

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (!I_RESETN);

	sequence rd_load_s;
		I_READ_PTR_CLK && !st.rd_clk_q && I_READ_PTR_LOAD;
	endsequence

	sequence rd_step_s;
		I_READ_PTR_CLK && !st.rd_clk_q && !I_READ_PTR_LOAD;
	endsequence

	sequence pix_pair_s;
		px_rise && st.px_on && !st.px_phase && !I_PIX_LOAD && !I_BLANK;
	endsequence

	read_load_a: assert property (rd_load_s |=> // [R20]
		st.read_ptr == one_hot($past(I_START_ROW)))
		else $error("read pointer not preloaded from start row");

	read_step_a: assert property (rd_step_s |=> // [R20]
		st.read_ptr == {$past(st.read_ptr[LINES-2:0]), 1'b0})
		else $error("read pointer did not advance one line");

	ptr_onehot_a: assert property ( // [R20]
		$onehot0(st.read_ptr) && $onehot0(st.shut_ptr))
		else $error("line pointer not one-hot");

	ptr_indep_a: assert property ( // [R9]
		rd_rise && !sh_rise |=> $stable(st.shut_ptr))
		else $error("shutter pointer moved with read pointer");

	blank_clear_a: assert property (I_BLANK |=> !st.px_on) // [R22]
		else $error("blanking did not clear pixel pointer");

	pix_two_a: assert property (pix_pair_s |=> // [R21]
		$stable(st.px_col) && st.px_phase)
		else $error("pixel advanced on first pixel clock");

	pix_order_a: assert property ( // [R5]
		$changed(st.px_col) && st.px_on && $past(st.px_on) |->
		st.px_col == ($past(px_rise && I_PIX_LOAD) ? $past(I_START_COL)
			: COL_W'($past(st.px_col) + 1'b1)))
		else $error("pixel pointer not stepping left to right");

	reset_route_a: assert property ( // [R10]
		I_BLANK && I_LINE_RESET && I_PTR_CHOICE && !sh_rise |=>
		st.line_reset == st.shut_ptr)
		else $error("shutter line reset misrouted");

	reset_blank_a: assert property ( // [R10]
		!I_BLANK |=> st.line_reset == '0 && !st.col_sample)
		else $error("line reset or column copy outside blanking");

	cal_black_a: assert property ( // [R19]
		st.gain_black && I_ADC_VALID && !O_PIX_VALID |=>
		O_PIX_DATA.black && O_PIX_DATA.sample == BLACK_LEVEL)
		else $error("calibration did not force black samples");
endmodule

// ===== verif/isrs_ctrl_model.sv
/*
 * Stream sink model of the timing controller and its black line memory, one entry per column.
 * Assumes words arrive by valid/ready on the sequencer clock.
 */
`timescale 1ns/100ps
module isrs_ctrl_model
	import isrs_pkg::*;
(
	input  wire logic                 i_clk,      // clock
	input  wire logic                 i_resetn,   // async reset, low
	input  wire logic                 i_stall,    // hold off the stream
	input  wire logic                 i_subtract, // 0 store, 1 correct
	input  wire logic                 i_valid,    // word offered
	input  wire isrs_pkg::isrs_pix_t  i_data,     // stream word
	output logic                      o_ready     // word taken
);
	logic [SAMPLE_W-1:0] black_mem [PIXELS];
	isrs_pix_t           last;
	logic [SAMPLE_W-1:0] result;
	int                  count;

	assign o_ready = i_resetn && !i_stall;

	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			count <= 0;
		end else if (i_valid && o_ready) begin
			count <= count + 1;
			last  <= i_data;
			if (!i_subtract) begin
				black_mem[i_data.column] <= i_data.sample;
			end else begin
				result <= i_data.sample - black_mem[i_data.column];
			end
		end
	end
endmodule

// ===== verif/test_isrs_top.sv
/*
 * Self-checking bench of the readout sequencer.
 * Assumes a 10 MHz clock; inputs change 1 ns after each rising edge.
 */
`timescale 1ns/100ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin err_total++; \
	$display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module test_isrs_top;
	import isrs_pkg::*;
	logic clk = 0, rstn = 0, corr = 0, rclk = 0, rld = 0, sclk = 0;
	logic sld = 0, blank = 0, cpre = 0, lrst = 0, choice = 0, cal = 0;
	logic pclk = 0, pld = 0, avalid = 0, stall = 1, sub = 0;
	logic [ROW_W-1:0]    row = 0;
	logic [COL_W-1:0]    col = 0;
	logic [SAMPLE_W-1:0] adata = 0;
	logic [LINES-1:0]    rd_line, sh_line, rst_line, one = 1;
	logic [COL_W-1:0]    pix_col;
	logic                samp, byp, gblk, pact, ardy, pvalid, pready;
	isrs_pix_t           pdata;
	int                  err_total = 0, checks = 0;
	// window (00A,3FC)-(00C,3FD); its end lives only in these counts
	localparam logic [ROW_W-1:0] W_ROW  = 10'h00A;
	localparam logic [COL_W-1:0] W_COL  = 10'h3FC;
	localparam int               N_ROWS = 3;
	localparam int               N_COLS = 2;
	localparam int               EXP_LN = 2;

	always #50 clk = ~clk;

	isrs_top #(.FIFO_DEPTH(8)) dut_u (.I_CLK(clk), .I_RESETN(rstn),
		.I_CORR_MODE(corr), .I_START_ROW(row), .I_START_COL(col),
		.I_READ_PTR_CLK(rclk), .I_READ_PTR_LOAD(rld),
		.I_SHUT_PTR_CLK(sclk), .I_SHUT_PTR_LOAD(sld), .I_BLANK(blank),
		.I_COL_PRELOAD(cpre), .I_LINE_RESET(lrst), .I_PTR_CHOICE(choice),
		.I_CAL(cal), .I_PIX_CLK(pclk), .I_PIX_LOAD(pld),
		.I_ADC_VALID(avalid), .I_ADC_DATA(adata), .I_PIX_READY(pready),
		.O_READ_LINE(rd_line), .O_SHUT_LINE(sh_line),
		.O_LINE_RESET(rst_line), .O_COL_SAMPLE(samp), .O_COL_BYPASS(byp),
		.O_GAIN_BLACK(gblk), .O_PIX_COL(pix_col), .O_PIX_ACTIVE(pact),
		.O_ADC_READY(ardy), .O_PIX_VALID(pvalid), .O_PIX_DATA(pdata));

	isrs_ctrl_model p_u (.i_clk(clk), .i_resetn(rstn), .i_stall(stall),
		.i_subtract(sub), .i_valid(pvalid), .i_data(pdata),
		.o_ready(pready));

	task automatic tick(input int n = 1);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// pointer clock rise then fall: 200 ns period, 100 ns high
	task automatic ptr_rise(input logic rd, input logic ld);
		rclk = rd; rld = rd & ld; sclk = !rd; sld = !rd & ld;
		tick();
		rclk = 0; sclk = 0; rld = 0; sld = 0;
		tick();
	endtask

	task automatic pix_rise(input logic ld);
		pclk = 1; pld = ld;
		tick();
		pclk = 0; pld = 0;
		tick();
	endtask

	task automatic drain();
		int n;
		stall = 0;
		n = 0;
		while (pvalid !== 1'b0 && n < 50) begin
			tick();
			n++;
		end
		`CHK("drain", 1'b0, pvalid)
		stall = 1;
	endtask

	task automatic test_pointers();
		row = 10'h3FE;
		ptr_rise(1, 1);
		`CHK("read load", one << 10'h3FE, rd_line)
		row = 10'h005;
		ptr_rise(0, 1);
		`CHK("shut load", one << 10'h005, sh_line)
		`CHK("read kept", one << 10'h3FE, rd_line)
		ptr_rise(1, 0);
		`CHK("read step", one << 10'h3FF, rd_line)
		ptr_rise(1, 0);
		`CHK("past last", {LINES{1'b0}}, rd_line)
		ptr_rise(0, 0);
		`CHK("shut step", one << 10'h006, sh_line)
		$display("test pointers done");
	endtask

	task automatic test_blanking();
		row = 10'h007;
		ptr_rise(1, 1);
		blank = 1; lrst = 1; cpre = 1; choice = 1;
		tick();
		`CHK("reset shut", one << 10'h006, rst_line)
		`CHK("col sample", 1'b1, samp)
		choice = 0;
		tick();
		`CHK("reset read", one << 10'h007, rst_line)
		blank = 0;
		tick();
		`CHK("no blank", {LINES{1'b0}}, rst_line)
		`CHK("no sample", 1'b0, samp)
		lrst = 0; cpre = 0;
		$display("test blanking done");
	endtask

	task automatic test_pixels();
		col = 10'h3FE;
		pix_rise(1);
		`CHK("pix load", 10'h3FE, pix_col)
		`CHK("pix on", 1'b1, pact)
		pix_rise(0);
		`CHK("half step", 10'h3FE, pix_col)
		pix_rise(0);
		`CHK("pix step", 10'h3FF, pix_col)
		pix_rise(0);
		pix_rise(0);
		`CHK("line end", 1'b0, pact)
		col = 10'h020;
		pix_rise(1);
		blank = 1;
		tick();
		`CHK("blank clr", 1'b0, pact)
		blank = 0;
		pix_rise(0);
		pix_rise(0);
		`CHK("no reload", 1'b0, pact)
		pix_rise(1);
		`CHK("reload", 10'h020, pix_col)
		$display("test pixels done");
	endtask

	task automatic test_cal();
		`CHK("no bypass", 1'b0, byp)
		cal = 1; corr = 1;
		tick();
		`CHK("gain black", 1'b1, gblk)
		`CHK("bypass", 1'b1, byp)
		avalid = 1; adata = 12'hABC;
		tick();
		avalid = 0; cal = 0;
		drain();
		`CHK("black flag", 1'b1, p_u.last.black)
		`CHK("black zero", 12'h000, p_u.last.sample)
		$display("test cal done");
	endtask

	task automatic test_stream();
		avalid = 1;
		for (int i = 0; i < 9; i++) begin
			adata = 12'h100 + 12'(i);
			tick();
		end
		`CHK("full", 1'b0, ardy)
		avalid = 0;
		drain();
		`CHK("count", 9, p_u.count)
		`CHK("last kept", 12'h107, p_u.last.sample)
		`CHK("column", 10'h020, p_u.last.column)
		sub = 1; avalid = 1; adata = 12'h300;
		tick();
		avalid = 0;
		drain();
		`CHK("corrected", 12'h1F9, p_u.result)
		$display("test stream done");
	endtask

	// dark sweep of the whole array with the shutter pointer
	task automatic test_dark();
		int bad;
		bad = 0;
		corr = 1; row = 10'h000;
		ptr_rise(0, 1);
		for (int y = 0; y < LINES; y++) begin
			blank = 1; lrst = 1; choice = 1;
			tick();
			if (rst_line !== (one << y)) begin
				bad++;
			end
			blank = 0; lrst = 0;
			ptr_rise(0, 0);
		end
		`CHK("dark lines", 0, bad)
		`CHK("sweep end", {LINES{1'b0}}, sh_line)
		$display("test dark done");
	endtask

	// destructive frame over the window: expose, then line by line
	task automatic test_frame();
		int bad;
		int c0;
		bad = 0;
		c0 = p_u.count;
		corr = 0; sub = 0; row = W_ROW; col = W_COL;
		ptr_rise(1, 1);
		ptr_rise(0, 1);
		`CHK("init read", one << W_ROW, rd_line)
		`CHK("init shut", one << W_ROW, sh_line)
		for (int e = 0; e <= EXP_LN; e++) begin
			blank = 1; lrst = 1; choice = 1;
			tick();
			if (rst_line !== (one << (W_ROW + e))) begin
				bad++;
			end
			// one short line time before the shutter steps on
			blank = 0; lrst = 0;
			tick(2);
			ptr_rise(0, 0);
		end
		`CHK("expose idle", one << W_ROW, rd_line)
		`CHK("expose lines", 0, bad)
		for (int y = 0; y < N_ROWS; y++) begin
			blank = 1; cpre = 1;
			tick();
			if (samp !== 1'b1) begin
				bad++;
			end
			cpre = 0; lrst = 1; choice = 0;
			tick();
			if (rst_line !== (one << (W_ROW + y))) begin
				bad++;
			end
			choice = 1;
			tick();
			if (rst_line !== (one << (W_ROW + EXP_LN + 1 + y))) begin
				bad++;
			end
			// no second read reset: hold blanking, calibrate per line
			lrst = 0; cal = 1;
			tick();
			if (gblk !== 1'b1) begin
				bad++;
			end
			blank = 0; cal = 0;
			ptr_rise(0, 0);
			pix_rise(1);
			for (int x = 0; x < N_COLS; x++) begin
				if (pix_col !== W_COL + x) begin
					bad++;
				end
				avalid = 1; adata = 12'(16 * y + x);
				tick();
				avalid = 0;
				pix_rise(0);
				pix_rise(0);
			end
			ptr_rise(1, 0);
		end
		`CHK("read lines", 0, bad)
		`CHK("read end", one << (W_ROW + N_ROWS), rd_line)
		drain();
		`CHK("window words", c0 + N_ROWS * N_COLS, p_u.count)
		`CHK("window col", 10'h3FD, p_u.last.column)
		`CHK("window last", 12'h021, p_u.last.sample)
		$display("test frame done");
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		#1000000;
		err_total++;
		conclude();
	end

	initial begin
		tick(4);
		`CHK("rst read", {LINES{1'b0}}, rd_line)
		`CHK("rst ready", 1'b1, ardy)
		`CHK("rst valid", 1'b0, pvalid)
		rstn = 1;
		tick();
		test_pointers();
		test_blanking();
		test_pixels();
		test_cal();
		test_stream();
		test_dark();
		test_frame();
		conclude();
	end
endmodule
